// File: shared/osq_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, one word per register
// Notes:   Included by bare name
`ifndef OSQ_CFG_SVH
`define OSQ_CFG_SVH
`define OSQ_A_CTRL 12'h000
`define OSQ_A_CMD  12'h004
`define OSQ_A_STAT 12'h008
`define OSQ_A_SEQ  12'h00c
`define OSQ_A_BR   12'h010
`define OSQ_A_SIDX 12'h014
`define OSQ_A_ST0  12'h018
`define OSQ_A_ST1  12'h01c
`define OSQ_A_ST2  12'h020
`define OSQ_A_BASE 12'h024
`define OSQ_A_LVL  12'h028
`define OSQ_C_EXT  0
`define OSQ_C_KLK  1
`define OSQ_C_BEEP 2
`define OSQ_C_PON  3
`define OSQ_C_MODE 4
`define OSQ_C_RNG  5
`define OSQ_CTRL_RST 6'h00
`define OSQ_K_ON   0
`define OSQ_K_OFF  1
`define OSQ_K_STA  2
`define OSQ_K_STP  3
`define OSQ_K_HLD  4
`define OSQ_K_BR0  5
`define OSQ_K_BR1  6
`define OSQ_K_STO  7
`define OSQ_K_RCL  8
`define OSQ_K_FRS  9
`define OSQ_S_ERR  3
`define OSQ_S_REJ  5
`define OSQ_STEPS_MAX 8'hff
`define OSQ_JUMP_MAX  10'h3e7
`define OSQ_SLOTS     5'h1e
`define OSQ_TIME_MAX  24'h98967f
`define OSQ_TICK_NS   100000
`define OSQ_CLK_NS    50
`define OSQ_TICK_CYC  ((`OSQ_TICK_NS + `OSQ_CLK_NS - 1) / `OSQ_CLK_NS)
`endif

// File: shared/osq_pkg.sv
// Purpose: Types of the output sequencer
// Assumes: Nothing
// Notes:   Constants live in osq_cfg.svh
package osq_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} osq_st_e;
	typedef enum logic [1:0] {OP_CONST, OP_KEEP, OP_SWEEP} osq_op_e;
	typedef enum logic [3:0] {R_CTRL, R_CMD, R_STAT, R_SEQ, R_BR, R_SIDX,
		R_ST0, R_ST1, R_ST2, R_BASE, R_LVL, R_NONE} osq_reg_e;
	// One stored step: time in 0.1 ms units, levels dc/ac/freq
	typedef struct packed {
		logic [23:0]       tm;
		logic [2:0][15:0]  lvl;
		logic [2:0][1:0]   op;
		logic [1:0]        sync;
		logic [3:0]        wave;
	} osq_step_s;
	typedef struct packed {
		logic off, on, start, stop, hold, br0, br1;
	} osq_ext_s;
	typedef struct packed {
		logic ovp_ocp, pwr, pwr_sev, ctl, ctl_sev, temp;
	} osq_flt_s;
	typedef struct packed {
		logic       power, out_on, limit, busy;
		logic [1:0] sync;
	} osq_stat_s;
	typedef struct packed {
		logic [15:0] dc, ac, fr;
		logic [3:0]  wave;
	} osq_drv_s;
endpackage

// File: rtl/osq_top.sv
// Purpose: Step sequencer and supervisory control of a power source
// Assumes: One 20 MHz clock, APB register access
// Notes:   Analog and waveform datapaths live elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "osq_cfg.svh"
module osq_top #(
	parameter int TICK_CYC = `OSQ_TICK_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire osq_pkg::osq_ext_s ext_n,
	input  wire osq_pkg::osq_flt_s flt,
	input  wire logic              limit_in,
	input  wire logic              busy_in,
	input  wire logic              pwron_strap,
	output osq_pkg::osq_stat_s     stat,
	output osq_pkg::osq_drv_s      drv,
	output logic                   alarm,
	output logic                   prot_err,
	output logic                   lockout
);
	import osq_pkg::*;

	localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);

	// Address decode shared by read and write paths
	function automatic osq_reg_e reg_idx(input logic [11:0] a);
		if (a == `OSQ_A_CTRL) return R_CTRL;
		else if (a == `OSQ_A_CMD) return R_CMD;
		else if (a == `OSQ_A_STAT) return R_STAT;
		else if (a == `OSQ_A_SEQ) return R_SEQ;
		else if (a == `OSQ_A_BR) return R_BR;
		else if (a == `OSQ_A_SIDX) return R_SIDX;
		else if (a == `OSQ_A_ST0) return R_ST0;
		else if (a == `OSQ_A_ST1) return R_ST1;
		else if (a == `OSQ_A_ST2) return R_ST2;
		else if (a == `OSQ_A_BASE) return R_BASE;
		else if (a == `OSQ_A_LVL) return R_LVL;
		else return R_NONE;
	endfunction

	logic [5:0]  ctrl_q;
	logic [7:0]  cnt_q [4];
	logic [9:0]  jmp_q [4];
	logic [7:0]  br0_q [4];
	logic [7:0]  br1_q [4];
	logic [7:0]  sidx_q;
	osq_step_s   stg_q;
	osq_step_s   mem_q [1024];
	logic [31:0] base_q;
	logic [33:0] slot_q [30];
	logic        out_on_q;
	logic        rej_q;
	logic [1:0]  init_q;
	osq_st_e     st_q;
	osq_st_e     st_d;
	logic [7:0]  idx_q;
	logic [23:0] tmr_q;
	logic [11:0] tick_q;
	logic [9:0]  jrem_q;
	osq_step_s   stp_q;
	logic [31:0] acc_q [3];
	logic [31:0] inc_q [3];
	logic [6:0]  s1_q, s2_q, s3_q, lvl_q, lvl_d;
	osq_ext_s    fall_q;

	// three-flop synchroniser, level moves when stages 2 and 3 agree
	assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q   <= 7'h7f;
			s2_q   <= 7'h7f;
			s3_q   <= 7'h7f;
			lvl_q  <= 7'h7f;
			fall_q <= '0;
		end else begin
			s1_q   <= ext_n;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			lvl_q  <= lvl_d;
			fall_q <= lvl_q & ~lvl_d;
		end
	end

	// Bus strobes and command decoding
	logic        wr;
	osq_reg_e    widx;
	logic [31:0] cmd_w;
	osq_ext_s    ef;
	logic        ok, prot, sev, op_evt;
	logic        c_off, c_on, c_sta, c_stp, c_hld, c_br0, c_br1;
	logic        c_sto, c_rcl, c_frs, rc_bad;
	logic [4:0]  slot;
	logic        slot_ok;
	logic [1:0]  sel;
	assign wr    = psel & penable & pwrite;
	assign widx  = reg_idx(paddr);
	assign cmd_w = (wr && widx == R_CMD) ? pwdata : 32'h0;
	assign sel   = {ctrl_q[`OSQ_C_MODE], ctrl_q[`OSQ_C_RNG]};
	// pins count only while external control is enabled
	assign ef    = ctrl_q[`OSQ_C_EXT] ? fall_q : '0;
	// keylock and lockout gate everything but output off and status flag clears; keylock also passes its own release
	assign ok    = ~lockout & ~ctrl_q[`OSQ_C_KLK] & (init_q == 2'h2);
	assign c_off = cmd_w[`OSQ_K_OFF] | ef.off;
	assign c_on  = ok & (cmd_w[`OSQ_K_ON] | ef.on);
	assign c_sta = ok & (cmd_w[`OSQ_K_STA] | ef.start);
	assign c_stp = ok & (cmd_w[`OSQ_K_STP] | ef.stop);
	assign c_hld = ok & (cmd_w[`OSQ_K_HLD] | ef.hold);
	// branch inputs share the command path
	assign c_br0 = ok & (cmd_w[`OSQ_K_BR0] | ef.br0);
	assign c_br1 = ok & (cmd_w[`OSQ_K_BR1] | ef.br1) & ~c_br0;
	assign c_sto = ok & cmd_w[`OSQ_K_STO];
	assign c_rcl = ok & cmd_w[`OSQ_K_RCL];
	assign c_frs = ok & cmd_w[`OSQ_K_FRS];
	assign slot    = pwdata[20:16];
	assign slot_ok = (slot != 5'h00) && (slot <= `OSQ_SLOTS);
	// recall while output on is refused
	assign rc_bad  = c_rcl & (out_on_q | ~slot_ok);
	assign prot    = |flt;
	assign sev     = flt.pwr_sev | flt.ctl_sev;
	assign op_evt  = rc_bad | (c_sto & ~slot_ok) |
		(~ok & (|cmd_w[9:0] & ~cmd_w[`OSQ_K_OFF]));

	// Sequencer next-state and step fetch
	logic [7:0]  brt, ld_idx;
	logic        br_ok, last, tick, expire, ld, wrap, fresh;
	osq_step_s   nxt;
	logic [23:0] ntm;
	assign brt    = c_br0 ? br0_q[sel] : br1_q[sel];
	assign br_ok  = (c_br0 | c_br1) & (brt < cnt_q[sel]);
	assign last   = idx_q == 8'(cnt_q[sel] - 8'h01);
	assign tick   = (st_q == ST_RUN) && (tick_q == TICK_LAST);
	assign expire = tick && (tmr_q <= 24'h000001);
	assign nxt    = mem_q[{sel, ld_idx}];
	// Zero time would divide by zero in the sweep, so it runs one tick
	assign ntm    = (nxt.tm == 24'h0) ? 24'h000001 : nxt.tm;

	always_comb begin
		st_d   = st_q;
		ld     = 1'b0;
		ld_idx = 8'h00;
		wrap   = 1'b0;
		fresh  = 1'b0;
		if (c_stp || prot) begin
			st_d = ST_IDLE;
		// branch loads its target at once
		end else if (br_ok) begin
			ld     = 1'b1;
			ld_idx = brt;
			fresh  = st_q == ST_IDLE;
			st_d   = ST_RUN;
		end else if (c_sta) begin
			if (st_q == ST_IDLE) begin
				ld    = 1'b1;
				fresh = 1'b1;
			end
			st_d = ST_RUN;
		end else if (c_hld && st_q == ST_RUN) begin
			st_d = ST_HOLD;
		// advance, wrap on jump count, or stop
		end else if (expire) begin
			if (!last) begin
				ld     = 1'b1;
				ld_idx = 8'(idx_q + 8'h01);
			// zero jump count repeats without end
			end else if (jmp_q[sel] == 10'h0 || jrem_q > 10'h001) begin
				ld   = 1'b1;
				wrap = 1'b1;
			end else begin
				st_d = ST_IDLE;
			end
		end
	end

	// tick prescaler and step timer; hold freezes both
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= ST_IDLE;
			idx_q  <= 8'h00;
			tmr_q  <= 24'h0;
			tick_q <= 12'h0;
			jrem_q <= 10'h0;
			stp_q  <= '0;
		end else begin
			st_q <= st_d;
			if (ld) begin
				idx_q  <= ld_idx;
				stp_q  <= nxt;
				tmr_q  <= ntm;
				tick_q <= 12'h0;
			end else if (st_q == ST_RUN) begin
				tick_q <= tick ? 12'h0 : 12'(tick_q + 12'h001);
				if (tick)
					tmr_q <= 24'(tmr_q - 24'h000001);
			end
			if (fresh)
				jrem_q <= jmp_q[sel];
			else if (wrap && jrem_q != 10'h0)
				jrem_q <= 10'(jrem_q - 10'h001);
		end
	end

	// per-parameter constant, keep or linear sweep
	for (genvar p = 0; p < 3; p++) begin : g_par
		logic signed [32:0] dif;
		logic signed [32:0] quo;
		assign dif = $signed({1'b0, nxt.lvl[p], 16'h0}) - $signed({1'b0, acc_q[p]});
		// One-shot divide at step load; truncation never overshoots
		assign quo = dif / $signed({9'h0, ntm});
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				acc_q[p] <= 32'h0;
				inc_q[p] <= 32'h0;
			end else if (ld) begin
				inc_q[p] <= (nxt.op[p] == OP_SWEEP) ? 32'(quo) : 32'h0;
				if (nxt.op[p] == OP_CONST)
					acc_q[p] <= {nxt.lvl[p], 16'h0};
			end else if (tick) begin
				acc_q[p] <= 32'(acc_q[p] + inc_q[p]);
			end
		end
	end

	// settings and sequence tables, indexed by mode and range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `OSQ_CTRL_RST;
			sidx_q <= 8'h00;
			stg_q  <= '0;
			base_q <= 32'h0;
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= 8'h01;
				jmp_q[i] <= 10'h001;
				br0_q[i] <= 8'h00;
				br1_q[i] <= 8'h00;
			end
		end else begin
			// Strap caught one edge after release, not by reset
			if (init_q == 2'h0)
				ctrl_q[`OSQ_C_PON] <= pwron_strap;
			// control stays writable so keylock can be released
			if (wr && widx == R_CTRL && (ok || !pwdata[`OSQ_C_KLK]) && !lockout)
				ctrl_q <= ok ? pwdata[5:0] : (ctrl_q & ~6'h02);
			if (ok && wr && widx == R_SEQ) begin
				if (pwdata[7:0] != 8'h00)
					cnt_q[sel] <= pwdata[7:0];
				if (pwdata[17:8] <= `OSQ_JUMP_MAX)
					jmp_q[sel] <= pwdata[17:8];
			end
			if (ok && wr && widx == R_BR) begin
				br0_q[sel] <= pwdata[7:0];
				br1_q[sel] <= pwdata[15:8];
			end
			if (ok && wr && widx == R_SIDX)
				sidx_q <= pwdata[7:0];
			if (ok && wr && widx == R_ST0 && pwdata[23:0] <= `OSQ_TIME_MAX)
				stg_q.tm <= pwdata[23:0];
			if (ok && wr && widx == R_ST1)
				stg_q.lvl[1:0] <= pwdata;
			if (ok && wr && widx == R_BASE)
				base_q <= pwdata;
			// recall loads mode, range and levels
			if (c_rcl && !rc_bad) begin
				{ctrl_q[`OSQ_C_MODE], ctrl_q[`OSQ_C_RNG], base_q} <= slot_q[slot - 5'h01];
			end
			// factory reset of the basic settings
			if (c_frs) begin
				ctrl_q[`OSQ_C_MODE] <= 1'b0;
				ctrl_q[`OSQ_C_RNG]  <= 1'b0;
				base_q              <= 32'h0;
			end
		end
	end

	// step word written on the final staging write
	always_ff @(posedge pclk) begin
		if (ok && wr && widx == R_ST2 && sidx_q != `OSQ_STEPS_MAX)
			mem_q[{sel, sidx_q}] <= {stg_q.tm, pwdata[15:0], stg_q.lvl[1:0],
				pwdata[27:22], pwdata[21:20], pwdata[19:16]};
		// slots hold mode, range and levels
		if (c_sto && slot_ok)
			slot_q[slot - 5'h01] <= {sel, base_q};
	end

	// Output and protection state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_q   <= 2'h0;
			out_on_q <= 1'b0;
			prot_err <= 1'b0;
			lockout  <= 1'b0;
			rej_q    <= 1'b0;
			alarm    <= 1'b0;
		end else begin
			if (init_q != 2'h2)
				init_q <= 2'(init_q + 2'h1);
			// any fault forces the output off
			if (prot || c_off)
				out_on_q <= 1'b0;
			else if (c_on || (init_q == 2'h1 && ctrl_q[`OSQ_C_PON]))
				out_on_q <= 1'b1;
			// Set wins over a clear in the same cycle
			if (prot)
				prot_err <= 1'b1;
			else if (wr && widx == R_STAT && pwdata[`OSQ_S_ERR])
				prot_err <= 1'b0;
			// severe faults lock out until reset
			if (sev)
				lockout <= 1'b1;
			if (rc_bad)
				rej_q <= 1'b1;
			else if (wr && widx == R_STAT && pwdata[`OSQ_S_REJ])
				rej_q <= 1'b0;
			// alarm ignores beep setting for protection
			alarm <= prot | prot_err | (ctrl_q[`OSQ_C_BEEP] & op_evt);
		end
	end

	// status and drive outputs registered every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= '0;
			drv  <= '0;
		end else begin
			stat.power  <= 1'b1;
			stat.out_on <= out_on_q;
			stat.limit  <= limit_in;
			stat.busy   <= busy_in;
			// step sync bits while a sequence is active
			stat.sync   <= (st_q == ST_IDLE) ? 2'h0 : stp_q.sync;
			drv.dc      <= (st_q == ST_IDLE) ? base_q[15:0] : acc_q[0][31:16];
			drv.ac      <= (st_q == ST_IDLE) ? base_q[31:16] : acc_q[1][31:16];
			drv.fr      <= acc_q[2][31:16];
			drv.wave    <= stp_q.wave;
		end
	end

	// APB: zero-wait reply prepared in the setup cycle
	osq_reg_e    ridx;
	logic [31:0] rd;
	assign ridx = reg_idx(paddr);
	always_comb begin
		case (ridx)
			R_CTRL:  rd = {26'h0, ctrl_q};
			R_STAT:  rd = {14'h0, stat.sync, idx_q, 2'h0, rej_q, lockout, prot_err,
				st_q == ST_HOLD, st_q != ST_IDLE, out_on_q};
			R_SEQ:   rd = {14'h0, jmp_q[sel], cnt_q[sel]};
			R_BR:    rd = {16'h0, br1_q[sel], br0_q[sel]};
			R_SIDX:  rd = {24'h0, sidx_q};
			R_ST0:   rd = {8'h0, stg_q.tm};
			R_ST1:   rd = stg_q.lvl[1:0];
			R_BASE:  rd = base_q;
			R_LVL:   rd = {drv.ac, drv.dc};
			default: rd = 32'h0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (ridx == R_NONE);
			prdata  <= (psel & ~penable & ~pwrite) ? rd : 32'h0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_adv;
		st_q == ST_RUN && expire && !last && !c_stp && !prot && !br_ok && !c_sta && !c_hld;
	endsequence
	sequence s_frozen;
		st_q == ST_HOLD && !c_sta && !c_stp && !br_ok ##1 st_q == ST_HOLD;
	endsequence
	property p_fault_off;
		prot |=> !out_on_q ##1 !stat.out_on;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault left output on");
	property p_lock;
		sev |=> lockout [*4];
	endproperty
	a_lock: assert property (p_lock) else $error("severe fault no lockout");
	property p_ctl_off;
		flt.ctl |=> !out_on_q;
	endproperty
	a_ctl_off: assert property (p_ctl_off) else $error("control fault output on");
	property p_temp;
		flt.temp |=> ##1 !stat.out_on;
	endproperty
	a_temp: assert property (p_temp) else $error("hot output still on");
	property p_alarm;
		prot |=> alarm;
	endproperty
	a_alarm: assert property (p_alarm) else $error("no alarm on fault");
	property p_recall;
		c_rcl && out_on_q |=> rej_q && $stable(base_q);
	endproperty
	a_recall: assert property (p_recall) else $error("recall taken with output on");
	property p_hold;
		s_frozen |-> $stable(tmr_q) && $stable(idx_q);
	endproperty
	a_hold: assert property (p_hold) else $error("timer ran in hold");
	// Load time of the step just fetched, for the advance check
	logic [23:0] ntm_past_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ntm_past_q <= 24'h0;
		else
			ntm_past_q <= ntm;
	end
	property p_adv;
		s_adv |=> idx_q == 8'($past(idx_q) + 8'h01) && tmr_q == ntm_past_q;
	endproperty
	a_adv: assert property (p_adv) else $error("step did not advance");
	property p_sync;
		st_q != ST_IDLE |=> stat.sync == $past(stp_q.sync);
	endproperty
	a_sync: assert property (p_sync) else $error("sync lines wrong");
	property p_ext_off;
		ctrl_q[`OSQ_C_EXT] && fall_q.off |=> !out_on_q;
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("external off ignored");
	property p_pulse;
		fall_q.on |=> !fall_q.on;
	endproperty
	a_pulse: assert property (p_pulse) else $error("edge pulse too long");
	property p_klk;
		ctrl_q[`OSQ_C_KLK] && !out_on_q && init_q == 2'h2 |=> !out_on_q;
	endproperty
	a_klk: assert property (p_klk) else $error("keylock let output on");
endmodule
`default_nettype wire

// File: testbench/osq_ext_ctl.sv
// Purpose: Model of the external controller on the control pins
// Assumes: Pins are pulled up, so an idle pin reads high
// Notes:   press() holds one pin low long enough to pass the filter
`timescale 1ns/1ps
`default_nettype none
module osq_ext_ctl (
	input  wire logic         pclk,
	output osq_pkg::osq_ext_s ext_n
);
	import osq_pkg::*;
	// Pull-ups hold every pin high between presses
	initial ext_n = '1;
	// falling edge acts
	// Low for six cycles, clear of the three-cycle filter
	task automatic press(input int k);
		@(posedge pclk);
		ext_n[k] <= 1'b0;
		repeat (6) @(posedge pclk);
		ext_n[k] <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: testbench/osq_top_tb.sv
// Purpose: Self-checking bench of the output sequencer
// Assumes: Short tick so step times stay a few cycles
// Notes:   Bus answers are checked from a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "osq_cfg.svh"
module osq_top_tb;
	import osq_pkg::*;
	localparam int TK = 4;
	localparam int P_OFF = 6, P_ON = 5, P_STA = 4, P_STP = 3, P_HLD = 2, P_BR0 = 1, P_BR1 = 0;
	typedef struct packed {logic [31:0] exp; logic [31:0] msk; logic err;} osq_note_s;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        alarm, prot_err, lockout, limit_in, busy_in, pwron_strap;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] rnd = 16'h0037;
	osq_ext_s    ext_n;
	osq_flt_s    flt;
	osq_stat_s   stat;
	osq_drv_s    drv;
	osq_note_s   notes[$];
	osq_note_s   nt;
	logic [3:0]  wv [2];
	int          n_errors = 0, comparisons = 0, cyc = 0, n;

	osq_top #(.TICK_CYC(TK)) i_osq_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_n(ext_n), .flt(flt), .limit_in(limit_in),
		.busy_in(busy_in), .pwron_strap(pwron_strap), .stat(stat), .drv(drv),
		.alarm(alarm), .prot_err(prot_err), .lockout(lockout));
	osq_ext_ctl i_osq_ext_ctl (.pclk(pclk), .ext_n(ext_n));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic fail(input string m);
		n_errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) fail(m);
	endtask

	task automatic stop_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard, well above the longest scenario
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail("timeout");
			stop_test();
		end
	end

	// Each completed transfer takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			if (notes.size() == 0) begin
				fail("answer without request");
			end else begin
				nt = notes.pop_front();
				comparisons++;
				if (((prdata & nt.msk) !== nt.exp) || (pslverr !== nt.err)) fail("bus answer");
			end
		end
	end

	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m, input logic er);
		@(posedge pclk);
		notes.push_back('{e, m, er});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, e, m, 1'b0);
	endtask

	task automatic cmd(input int k);
		wr(`OSQ_A_CMD, 32'h1 << k);
	endtask

	// Random waveform code goes with every step
	task automatic step(input logic [7:0] i, input logic [23:0] tm, input logic [1:0] s);
		rnd = lfsr(rnd);
		wv[i[0]] = rnd[3:0];
		wr(`OSQ_A_SIDX, {24'h0, i});
		wr(`OSQ_A_ST0, {8'h0, tm});
		wr(`OSQ_A_ST1, 32'h0200_0100);
		wr(`OSQ_A_ST2, {10'h0, s, rnd[3:0], 16'h1234});
	endtask

	task automatic wait_sync(input logic [1:0] v, output int c);
		c = 0;
		while (stat.sync !== v && c < 400) begin
			@(negedge pclk);
			c++;
		end
		if (c >= 400) fail("sync value not reached");
	endtask

	task automatic do_reset(input logic strap);
		@(posedge pclk);
		presetn <= 1'b0;
		pwron_strap <= strap;
		flt <= '0;
		repeat (2) @(posedge pclk);
		chk(stat === '0 && lockout === 1'b0, "outputs live in reset");
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		presetn = 1'b0;
		flt = '0;
		limit_in = 1'b0;
		busy_in = 1'b0;
		pwron_strap = 1'b0;
		do_reset(1'b0);
		chk(stat.power === 1'b1, "power flag");
		rd(`OSQ_A_CTRL, 32'h0, 32'h3f);
		apb(1'b0, 12'h040, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
		// Limiter and busy levels follow random inputs
		repeat (8) begin
			rnd = lfsr(rnd);
			@(posedge pclk);
			limit_in <= rnd[0];
			busy_in <= rnd[1];
			repeat (2) @(posedge pclk);
			chk(stat.limit === rnd[0] && stat.busy === rnd[1], "limit or busy");
		end
		// Two steps, two passes, then the run ends
		wr(`OSQ_A_SEQ, 32'h0000_0202);
		step(8'h0, 24'h3, 2'h1);
		step(8'h1, 24'h3, 2'h2);
		cmd(`OSQ_K_STA);
		wait_sync(2'h1, n);
		wait_sync(2'h2, n);
		chk(n >= 3 * TK - 2 && n <= 3 * TK + 2, "step time");
		wait_sync(2'h1, n);
		chk(n <= 3 * TK + 2, "second pass");
		wait_sync(2'h2, n);
		repeat (3 * TK + 6) @(posedge pclk);
		rd(`OSQ_A_STAT, 32'h0, 32'h2);
		wr(`OSQ_A_CTRL, 32'h10);
		rd(`OSQ_A_SEQ, 32'h0000_0101, 32'h3_ffff);
		// Long steps, endless loop, driven from the pins
		wr(`OSQ_A_CTRL, 32'h1);
		rd(`OSQ_A_SEQ, 32'h0000_0202, 32'h3_ffff);
		wr(`OSQ_A_SEQ, 32'h0000_0002);
		wr(`OSQ_A_SEQ, 32'h0000_0000);
		rd(`OSQ_A_SEQ, 32'h0000_0002, 32'h3_ffff);
		step(8'h0, 24'd50, 2'h1);
		step(8'h1, 24'd50, 2'h2);
		wr(`OSQ_A_BR, 32'h0000_0001);
		i_osq_ext_ctl.press(P_STA);
		wait_sync(2'h1, n);
		i_osq_ext_ctl.press(P_BR0);
		wait_sync(2'h2, n);
		chk(n < 20, "branch 0 late");
		i_osq_ext_ctl.press(P_BR1);
		wait_sync(2'h1, n);
		chk(n < 20, "branch 1 late");
		i_osq_ext_ctl.press(P_HLD);
		rd(`OSQ_A_STAT, 32'h4, 32'h4);
		repeat (250) @(posedge pclk);
		chk(stat.sync === 2'h1, "hold let the step move");
		chk(drv.dc === 16'h0100 && drv.ac === 16'h0200 && drv.fr === 16'h1234, "levels");
		chk(drv.wave === wv[0], "step waveform");
		i_osq_ext_ctl.press(P_STA);
		rd(`OSQ_A_STAT, 32'h2, 32'h6);
		wait_sync(2'h2, n);
		i_osq_ext_ctl.press(P_STP);
		rd(`OSQ_A_STAT, 32'h0, 32'h6);
		// Output pins act only with external control on
		i_osq_ext_ctl.press(P_ON);
		repeat (4) @(posedge pclk);
		chk(stat.out_on === 1'b1, "on pin");
		i_osq_ext_ctl.press(P_OFF);
		repeat (4) @(posedge pclk);
		chk(stat.out_on === 1'b0, "off pin");
		wr(`OSQ_A_CTRL, 32'h0);
		cmd(`OSQ_K_ON);
		i_osq_ext_ctl.press(P_OFF);
		repeat (4) @(posedge pclk);
		chk(stat.out_on === 1'b1, "pin acted while disabled");
		// Recall refused while the output is on
		wr(`OSQ_A_BASE, 32'h0200_0100);
		wr(`OSQ_A_CMD, 32'h0001_0000 | (32'h1 << `OSQ_K_STO));
		wr(`OSQ_A_BASE, 32'h0000_0055);
		wr(`OSQ_A_CMD, 32'h0001_0000 | (32'h1 << `OSQ_K_RCL));
		rd(`OSQ_A_STAT, 32'h21, 32'h21);
		rd(`OSQ_A_BASE, 32'h0000_0055, 32'hffff_ffff);
		cmd(`OSQ_K_OFF);
		wr(`OSQ_A_STAT, 32'h20);
		wr(`OSQ_A_CMD, 32'h0001_0000 | (32'h1 << `OSQ_K_RCL));
		rd(`OSQ_A_STAT, 32'h0, 32'h21);
		rd(`OSQ_A_BASE, 32'h0200_0100, 32'hffff_ffff);
		chk(drv.dc === 16'h0100 && drv.ac === 16'h0200, "idle levels");
		cmd(`OSQ_K_FRS);
		rd(`OSQ_A_BASE, 32'h0, 32'hffff_ffff);
		// Keylock passes only release, output off and status flag clears
		wr(`OSQ_A_CTRL, 32'h2);
		cmd(`OSQ_K_ON);
		rd(`OSQ_A_STAT, 32'h0, 32'h1);
		wr(`OSQ_A_CTRL, 32'h0);
		cmd(`OSQ_K_ON);
		rd(`OSQ_A_STAT, 32'h1, 32'h1);
		wr(`OSQ_A_CTRL, 32'h2);
		cmd(`OSQ_K_OFF);
		rd(`OSQ_A_STAT, 32'h0, 32'h1);
		// Every fault source, fresh reset each, beep off
		for (int f = 0; f < 6; f++) begin
			do_reset(1'b0);
			cmd(`OSQ_K_ON);
			@(posedge pclk);
			flt <= osq_flt_s'(6'h20 >> f);
			repeat (3) @(posedge pclk);
			chk(stat.out_on === 1'b0 && alarm === 1'b1, "fault");
			chk(prot_err === 1'b1, "no error flag");
			flt <= '0;
			@(posedge pclk);
			chk(lockout === 1'(f == 2 || f == 4), "lockout");
		end
		// Output comes up on by itself with the setting on
		do_reset(1'b1);
		chk(stat.out_on === 1'b1, "power-on output");
		stop_test();
	end
endmodule
`default_nettype wire
